// file: rtl/icm_master.sv
// icm_master.sv: two-wire bus master with command decode, bit engine and registers
// assumes a single-cycle register port and open-drain pads resolved outside
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "icm_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// RQ1: transmit state, run only: send a byte, stay in transmit.
// RQ2: transmit or receive state, stop only: stop condition, go idle.
// RQ3: transmit state, stop and run: send a byte, stop, go idle.
// RQ4: transmit, direction clear, start and run: restart, send; with stop, stop and idle.
// RQ5: transmit, direction set, no ack, start run: restart, receive with nack, to receive.
// RQ6: transmit, direction set, no ack, stop start run: restart, send, stop, idle.
// RQ7: transmit, direction set, ack, start run: restart, receive with ack, to receive.
// RQ8: receive state, run only: receive byte with nack, stay in receive.
// RQ9: receive state, stop and run, no ack: receive last byte, stop, idle.
// RQ10: receive state, ack and run: receive byte and acknowledge, stay in receive.
// RQ11: receive, direction set, no ack, start run: restart, receive nack; stop ends idle.
// RQ12: receive, direction set, ack, start run: restart, receive with ack, stay.
// RQ13: receive, direction clear, start run: restart, send, to transmit; stop ends idle.
// RQ14: software asks stop in receive only after a data or address nack.
// RQ15: data register holds byte to send or byte received; resets to zero.
// RQ16: timer period field sets serial clock period, 1 to 255, resets to one.
// RQ17: each serial clock period is 6 units low and 4 units high.
// RQ18: mask bit set forwards the raw interrupt; clear blocks it.
// RQ19: error set on address nack, data nack or lost arbitration.
// RQ20: writing one to the clear bit clears raw interrupt; zero does nothing.
// RQ21: masked status is raw status gated by the mask.
// RQ22: illegal or unlisted commands cause no bus activity and no state change.
// RQ23: unit is 2*(1+period) clocks, so period is that times ten clocks.
module icm_master (
	input  wire logic             i_core_clk,
	input  wire logic             i_rst_n,
	input  wire icm_pkg::icm_addr_t i_addr,
	input  wire icm_pkg::icm_word_t i_wdata,
	input  wire logic             i_wr,
	input  wire logic             i_rd,
	output icm_pkg::icm_word_t    o_rdata,
	input  wire logic             i_scl,
	output logic                  o_scl,
	output logic                  o_scl_oe_n,
	input  wire logic             i_sda,
	output logic                  o_sda,
	output logic                  o_sda_oe_n,
	output logic                  o_irq
);
	import icm_pkg::*;

	icm_state_t st;
	icm_state_t next_st;

	////////////////////////////////////////////////////////////////////////////
	// command decode

	function automatic icm_op_t mk(input logic s, input logic x, input logic r,
		input logic a, input logic p, input icm_ctl_t nx);
		icm_op_t o;
		o.valid = 1'b1;
		o.start = s;
		o.xfer  = x;
		o.rx    = r;
		o.ack   = a;
		o.stop  = p;
		o.nxt   = nx;
		return o;
	endfunction : mk

	function automatic icm_op_t decode(input icm_ctl_t ctl, input logic rs,
		input logic [3:0] cmd);
		icm_op_t  o;
		logic     r;
		logic     s;
		logic     p;
		logic     a;
		icm_ctl_t tx_nx;
		icm_ctl_t rx_nx;
		o = '0;
		r = cmd[`ICM_CMD_RUN];
		s = cmd[`ICM_CMD_START];
		p = cmd[`ICM_CMD_STOP];
		a = cmd[`ICM_CMD_ACK];
		tx_nx = p ? ICM_CTL_IDLE : ICM_CTL_MTX;
		rx_nx = p ? ICM_CTL_IDLE : ICM_CTL_MRX;
		unique case (ctl)
			ICM_CTL_IDLE: begin
				if (s && r) begin
					if (!rs)
						o = mk(1'b1, 1'b1, 1'b0, 1'b0, p, tx_nx);
					else if (!a)
						o = mk(1'b1, 1'b1, 1'b1, 1'b0, p, rx_nx);
					else if (!p)
						o = mk(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, ICM_CTL_MRX);
				end
			end
			ICM_CTL_MTX: begin
				if (!s && r)
					o = mk(1'b0, 1'b1, 1'b0, 1'b0, p, tx_nx); // [RQ1] [RQ3]
				else if (!s && p)
					o = mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, ICM_CTL_IDLE); // [RQ2]
				else if (s && r && !rs)
					o = mk(1'b1, 1'b1, 1'b0, 1'b0, p, tx_nx); // [RQ4]
				else if (s && r && !a && !p)
					o = mk(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, ICM_CTL_MRX); // [RQ5]
				else if (s && r && !a)
					o = mk(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, ICM_CTL_IDLE); // [RQ6]
				else if (s && r && !p)
					o = mk(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, ICM_CTL_MRX); // [RQ7]
			end
			ICM_CTL_MRX: begin
				if (!s && r && !(a && p))
					o = mk(1'b0, 1'b1, 1'b1, a, p, rx_nx); // [RQ8] [RQ9] [RQ10]
				else if (!s && !r && p)
					o = mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, ICM_CTL_IDLE); // [RQ2]
				else if (s && r && !rs)
					o = mk(1'b1, 1'b1, 1'b0, 1'b0, p, tx_nx); // [RQ13]
				else if (s && r && !a)
					o = mk(1'b1, 1'b1, 1'b1, 1'b0, p, rx_nx); // [RQ11]
				else if (s && r && !p)
					o = mk(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, ICM_CTL_MRX); // [RQ12]
			end
			default: o = '0;
		endcase
		return o; // all else stays invalid [RQ22]
	endfunction : decode

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		icm_op_t    cmd_op;
		logic       tick;
		logic       slot_end;
		logic       tx;
		logic       sda_in;
		logic       sda_lo;
		logic       fin;
		icm_ctl_t   fin_ctl;
		cmd_op   = '0;
		tick     = 1'b0;
		slot_end = 1'b0;
		tx       = 1'b0;
		sda_in   = st.sda_s2;
		sda_lo   = ~st.sda_oe_n;
		fin      = 1'b0;
		fin_ctl  = st.op.nxt;
		next_st  = st;

		// pad synchronisers
		next_st.sda_s1 = i_sda;
		next_st.sda_s2 = st.sda_s1;
		next_st.scl_s1 = i_scl;
		next_st.scl_s2 = st.scl_s1;

		// register reads, data one cycle later
		next_st.rdata = '0;
		if (i_rd) begin
			unique case (i_addr)
				`ICM_OFF_SA:  next_st.rdata = {24'h000000, st.sa};
				`ICM_OFF_CS:  next_st.rdata = {25'h0000000, st.bbsy,
					(st.ctl == ICM_CTL_IDLE) && (st.ph == ICM_PH_IDLE),
					st.arb, st.dack, st.aack, st.err, st.ph != ICM_PH_IDLE};
				`ICM_OFF_DR:  next_st.rdata = {24'h000000, st.dat}; // [RQ15]
				`ICM_OFF_TPR: next_st.rdata = {24'h000000, st.timer_period};
				`ICM_OFF_IMR: next_st.rdata = {31'h00000000, st.im};
				`ICM_OFF_RIS: next_st.rdata = {31'h00000000, st.raw_interrupt_bit};
				`ICM_OFF_MIS: next_st.rdata = {31'h00000000, st.raw_interrupt_bit & st.im}; // [RQ21]
				default:      next_st.rdata = '0;
			endcase
		end

		// register writes
		if (i_wr) begin
			unique case (i_addr)
				`ICM_OFF_SA:  next_st.sa = i_wdata[7:0];
				`ICM_OFF_DR:  next_st.dat = i_wdata[7:0]; // [RQ15]
				`ICM_OFF_TPR: begin
					if (i_wdata[7:0] != 8'h00)
						next_st.timer_period = i_wdata[7:0]; // [RQ16]
				end
				`ICM_OFF_IMR: next_st.im = i_wdata[0];
				`ICM_OFF_ICR: begin
					if (i_wdata[0])
						next_st.raw_interrupt_bit = 1'b0; // [RQ20]
				end
				`ICM_OFF_CS: begin
					if (st.ph == ICM_PH_IDLE)
						cmd_op = decode(st.ctl, st.sa[0], i_wdata[3:0]);
				end
				default: ;
			endcase
		end

		// command launch
		if (cmd_op.valid) begin
			next_st.op    = cmd_op;
			next_st.pcnt  = '0;
			next_st.ucnt  = '0;
			next_st.bitn  = '0;
			next_st.shreg = cmd_op.start ? st.sa : st.dat;
			next_st.arb   = 1'b0;
			next_st.dack  = 1'b0;
			next_st.aack  = 1'b0;
			next_st.err   = 1'b0;
			if (cmd_op.start)
				next_st.ph = ICM_PH_START;
			else if (cmd_op.xfer)
				next_st.ph = ICM_PH_DATA;
			else
				next_st.ph = ICM_PH_STOP;
			if (cmd_op.start)
				next_st.bbsy = 1'b1;
		end

		// bit engine
		if (st.ph != ICM_PH_IDLE) begin
			// one unit is 2*(1+period) clocks; slave may stretch the high phase
			next_st.pcnt = st.pcnt + 9'h001;
			if (st.pcnt == {st.timer_period, 1'b1}) begin // [RQ23]
				if (st.ucnt > `ICM_SCL_LOW && !st.scl_s2) begin
					next_st.pcnt = st.pcnt;
				end else begin
					next_st.pcnt = '0;
					tick = 1'b1;
				end
			end
			if (tick) begin
				if (st.ucnt == `ICM_SLOT_LAST) begin
					next_st.ucnt = '0;
					slot_end = 1'b1;
				end else begin
					next_st.ucnt = st.ucnt + 4'h1;
				end
			end

			// pad drive: six units low, four high [RQ17]
			tx = (st.ph == ICM_PH_ADDR) || !st.op.rx;
			if (st.ucnt != 4'h0) begin
				unique case (st.ph)
					ICM_PH_START: sda_lo = st.ucnt >= `ICM_EDGE_UNIT;
					ICM_PH_STOP:  sda_lo = st.ucnt < `ICM_EDGE_UNIT;
					default: begin
						if (st.bitn < `ICM_BYTE_BITS)
							sda_lo = tx & ~st.shreg[7];
						else
							sda_lo = ~tx & st.op.ack; // [RQ10] [RQ8]
					end
				endcase
			end
			next_st.scl_oe_n = ~(st.ucnt < `ICM_SCL_LOW);
			next_st.sda_oe_n = ~sda_lo;

			if (slot_end) begin
				unique case (st.ph)
					ICM_PH_START: begin
						next_st.ph    = ICM_PH_ADDR;
						next_st.shreg = st.sa;
						next_st.bitn  = '0;
					end
					ICM_PH_STOP: begin
						fin = 1'b1;
						fin_ctl = ICM_CTL_IDLE; // [RQ2]
						next_st.bbsy = 1'b0;
					end
					default: begin
						if (st.bitn < `ICM_BYTE_BITS) begin
							next_st.shreg = {st.shreg[6:0], sda_in};
							next_st.bitn  = st.bitn + 4'h1;
							if (tx && st.shreg[7] && !sda_in) begin
								next_st.arb  = 1'b1; // [RQ19]
								next_st.err  = 1'b1;
								next_st.bbsy = 1'b0;
								fin = 1'b1;
								fin_ctl = ICM_CTL_IDLE;
							end
						end else if (tx && sda_in) begin
							if (st.ph == ICM_PH_ADDR)
								next_st.aack = 1'b1; // [RQ19]
							else
								next_st.dack = 1'b1;
							next_st.err = 1'b1;
							if (st.op.stop)
								next_st.ph = ICM_PH_STOP;
							else
								fin = 1'b1;
						end else if (st.ph == ICM_PH_ADDR) begin
							next_st.ph    = ICM_PH_DATA;
							next_st.shreg = st.dat;
							next_st.bitn  = '0;
						end else begin
							if (!tx)
								next_st.dat = st.shreg; // [RQ15]
							if (st.op.stop)
								next_st.ph = ICM_PH_STOP; // [RQ3] [RQ9]
							else
								fin = 1'b1;
						end
					end
				endcase
			end

			if (fin) begin
				next_st.ph  = ICM_PH_IDLE;
				next_st.ctl = fin_ctl;
				next_st.raw_interrupt_bit = 1'b1;
				// master holds the clock low between commands unless the next state is idle
				next_st.scl_oe_n = fin_ctl == ICM_CTL_IDLE;
				next_st.sda_oe_n = 1'b1;
			end
		end

		next_st.irq = next_st.raw_interrupt_bit & next_st.im; // [RQ18]
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st          <= '0;
			st.sda_s1   <= 1'b1;
			st.sda_s2   <= 1'b1;
			st.scl_s1   <= 1'b1;
			st.scl_s2   <= 1'b1;
			st.ctl      <= ICM_CTL_IDLE;
			st.ph       <= ICM_PH_IDLE;
			st.sa       <= `ICM_SA_RST;
			st.dat      <= `ICM_DR_RST;
			st.timer_period      <= `ICM_TPR_RST;
			st.scl_oe_n <= 1'b1;
			st.sda_oe_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign o_rdata    = st.rdata;
	assign o_irq      = st.irq;
	assign o_scl      = 1'b0;
	assign o_sda      = 1'b0;
	assign o_scl_oe_n = st.scl_oe_n;
	assign o_sda_oe_n = st.sda_oe_n;

endmodule : icm_master

// file: rtl/icm_consts.svh
// icm_consts.svh: offsets, field positions, reset values and timing counts
// assumes byte addresses on a 6-bit register port, 32-bit data words
`ifndef ICM_CONSTS_SVH
`define ICM_CONSTS_SVH

// register offsets
`define ICM_OFF_SA      6'h00
`define ICM_OFF_CS      6'h04
`define ICM_OFF_DR      6'h08
`define ICM_OFF_TPR     6'h0c
`define ICM_OFF_IMR     6'h10
`define ICM_OFF_RIS     6'h14
`define ICM_OFF_MIS     6'h18
`define ICM_OFF_ICR     6'h1c

// command field positions
`define ICM_CMD_RUN     0
`define ICM_CMD_START   1
`define ICM_CMD_STOP    2
`define ICM_CMD_ACK     3

// reset values
`define ICM_DR_RST      8'h00
`define ICM_TPR_RST     8'h01
`define ICM_SA_RST      8'h00

// serial clock phases in timer units, and the bit count of a byte
`define ICM_SCL_LOW     4'h6
`define ICM_SCL_HIGH    4'h4
`define ICM_SLOT_LAST   4'h9
`define ICM_BYTE_BITS   4'h8
`define ICM_EDGE_UNIT   4'h8

`endif

// file: rtl/icm_pkg.sv
// icm_pkg.sv: types of the two-wire master command sequencer
// assumes icm_consts.svh supplies all numbers but the widths and encodings set here
package icm_pkg;

	typedef logic [31:0] icm_word_t;
	typedef logic [5:0]  icm_addr_t;

	typedef enum logic [1:0] {
		ICM_CTL_IDLE = 2'b00,
		ICM_CTL_MTX  = 2'b01,
		ICM_CTL_MRX  = 2'b10
	} icm_ctl_t;

	typedef enum logic [2:0] {
		ICM_PH_IDLE  = 3'b000,
		ICM_PH_START = 3'b001,
		ICM_PH_ADDR  = 3'b010,
		ICM_PH_DATA  = 3'b011,
		ICM_PH_STOP  = 3'b100
	} icm_ph_t;

	typedef struct packed {
		logic     valid;
		logic     start;
		logic     xfer;
		logic     rx;
		logic     ack;
		logic     stop;
		icm_ctl_t nxt;
	} icm_op_t;

	typedef struct packed {
		logic      sda_s1;
		logic      sda_s2;
		logic      scl_s1;
		logic      scl_s2;
		icm_ctl_t  ctl;
		icm_ph_t   ph;
		icm_op_t   op;
		logic [8:0] pcnt;
		logic [3:0] ucnt;
		logic [3:0] bitn;
		logic [7:0] shreg;
		logic [7:0] sa;
		logic [7:0] dat;
		logic [7:0] timer_period;
		logic      im;
		logic      raw_interrupt_bit;
		logic      arb;
		logic      dack;
		logic      aack;
		logic      err;
		logic      bbsy;
		logic      scl_oe_n;
		logic      sda_oe_n;
		logic      irq;
		icm_word_t rdata;
	} icm_state_t;

endpackage : icm_pkg

// file: test/icm_master_properties.sv
// icm_master_properties.sv: port checks of the command sequencer
// assumes the register map and reset values of icm_consts.svh
`timescale 1ns/1ps
`include "icm_consts.svh"
module icm_master_properties (
	input wire logic               i_core_clk,
	input wire logic               i_rst_n,
	input wire icm_pkg::icm_addr_t i_addr,
	input wire icm_pkg::icm_word_t i_wdata,
	input wire logic               i_wr,
	input wire logic               i_rd,
	input wire icm_pkg::icm_word_t o_rdata,
	input wire logic               i_scl,
	input wire logic               o_scl,
	input wire logic               o_scl_oe_n,
	input wire logic               i_sda,
	input wire logic               o_sda,
	input wire logic               o_sda_oe_n,
	input wire logic               o_irq
);
	import icm_pkg::*;
	logic        mask_q;
	logic [7:0]  per_q;
	logic [15:0] low_cnt;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	////////////////////////////////////////////////////////////////////
	// mirrors of mask and period, length of clock low run
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mask_q  <= 1'b0;
			per_q   <= `ICM_TPR_RST;
			low_cnt <= 16'h0;
		end else begin
			if (i_wr && i_addr == `ICM_OFF_IMR)
				mask_q <= i_wdata[0];
			if (i_wr && i_addr == `ICM_OFF_TPR && i_wdata[7:0] != 8'h00)
				per_q <= i_wdata[7:0];
			low_cnt <= o_scl_oe_n ? 16'h0 : low_cnt + 16'h1;
		end
	end
	////////////////////////////////////////////////////////////////////
	property p_rd_quiet;
		!$past(i_rd) |-> o_rdata == 32'h0;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet)
		else $error("read data outside answer cycle");
	property p_rd_upper;
		$past(i_rd) |-> o_rdata[31:8] == 24'h0;
	endproperty
	a_rd_upper: assert property (p_rd_upper)
		else $error("upper read bits not zero");
	property p_per_rd;
		$past(i_rd) && $past(i_addr) == `ICM_OFF_TPR |-> o_rdata[7:0] == $past(per_q);
	endproperty
	a_per_rd: assert property (p_per_rd)
		else $error("period readback wrong");
	property p_mask_rd;
		$past(i_rd) && $past(i_addr) == `ICM_OFF_IMR |-> o_rdata == {31'h0, $past(mask_q)};
	endproperty
	a_mask_rd: assert property (p_mask_rd)
		else $error("mask readback wrong");
	property p_clr_rd;
		$past(i_rd) && $past(i_addr) == `ICM_OFF_ICR |-> o_rdata == 32'h0;
	endproperty
	a_clr_rd: assert property (p_clr_rd)
		else $error("clear register read not zero");
	property p_msk_rd;
		$past(i_rd) && $past(i_addr) == `ICM_OFF_MIS |-> o_rdata[0] == $past(o_irq);
	endproperty
	a_msk_rd: assert property (p_msk_rd)
		else $error("masked status differs from irq");
	property p_irq_gate;
		!mask_q |-> !o_irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("irq while masked");
	property p_pad_zero;
		o_scl == 1'b0 && o_sda == 1'b0;
	endproperty
	a_pad_zero: assert property (p_pad_zero)
		else $error("pad drive value not low");
	property p_low_len;
		$rose(o_scl_oe_n) |-> low_cnt >= 16'd12 * (16'(per_q) + 16'd1);
	endproperty
	a_low_len: assert property (p_low_len)
		else $error("clock low phase too short");
	c_irq: cover property ($rose(o_irq));
	c_slot: cover property ($rose(o_scl_oe_n));
	c_cmd: cover property (i_wr && i_addr == `ICM_OFF_CS);
endmodule : icm_master_properties
bind icm_master icm_master_properties u_props (.i_core_clk, .i_rst_n, .i_addr, .i_wdata,
	.i_wr, .i_rd, .o_rdata, .i_scl, .o_scl, .o_scl_oe_n, .i_sda, .o_sda, .o_sda_oe_n, .o_irq);

// file: test/icm_slave_model.sv
// icm_slave_model.sv: addressed slave, optional clock stretching
// assumes resolved pulled-up lines fed back on i_scl and i_sda
`timescale 1ns/1ps
module icm_slave_model #(
	parameter logic [6:0] ADDR = 7'h2a
) (
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	input  wire logic       i_stretch,
	input  wire logic [7:0] i_tx,
	output logic            o_scl_oe_n,
	output logic            o_sda_oe_n,
	output logic [7:0]      o_rx
);
	logic [7:0] sh = 8'h00;
	int         bitc = 0;
	logic       first = 1'b0;
	logic       sel = 1'b0;
	logic       rd = 1'b0;
	logic       mack = 1'b0;
	initial begin
		o_scl_oe_n = 1'b1;
		o_sda_oe_n = 1'b1;
		o_rx = 8'h00;
	end
	always @(negedge i_sda) begin
		if (i_scl) begin
			bitc = 0;
			first = 1'b1;
			rd = 1'b0;
		end
	end
	always @(posedge i_scl) begin
		if (bitc < 8)
			sh = {sh[6:0], i_sda};
		else
			mack = !i_sda;
		bitc = bitc + 1;
	end
	always @(negedge i_scl) begin
		if (bitc == 8) begin
			if (first) begin
				sel = (sh[7:1] == ADDR);
				rd = sh[0];
			end else if (!rd && sel)
				o_rx = sh;
			o_sda_oe_n = !(sel && (first || !rd));
		end else if (bitc == 9) begin
			bitc = 0;
			rd = rd && sel && (first || mack);
			first = 1'b0;
			o_sda_oe_n = rd ? i_tx[7] : 1'b1;
		end else if (rd && !first)
			o_sda_oe_n = i_tx[7 - bitc];
	end
	always @(i_tx) begin
		if (rd && !first && bitc == 0)
			o_sda_oe_n = i_tx[7];
	end
	always @(negedge i_scl) begin
		if (i_stretch) begin
			o_scl_oe_n = 1'b0;
			#2000 o_scl_oe_n = 1'b1;
		end
	end
endmodule : icm_slave_model

// file: test/icm_master_tb_top.sv
// icm_master_tb_top.sv: self-checking bench of the command sequencer
// assumes the slave model on the bus and the bound checker
`timescale 1ns/1ps
`include "icm_consts.svh"
module icm_master_tb_top;
	import icm_pkg::*;
	logic      i_core_clk, i_rst_n, i_wr, i_rd, stretch, msk, raw_exp;
	icm_addr_t i_addr;
	icm_word_t i_wdata, o_rdata, v;
	logic      m_scl_oe_n, m_sda_oe_n, s_scl_oe_n, s_sda_oe_n, o_irq;
	logic [7:0] tx, rx_s, dat, tp;
	logic [15:0] s;
	int        err_count, checks, rises;
	time       tlast, gap;
	wire       scl = m_scl_oe_n & s_scl_oe_n;
	wire       sda = m_sda_oe_n & s_sda_oe_n;
	localparam logic [15:0] steps [29] = '{16'h0300, 16'h0100, 16'h0300,
		16'h1b10, 16'h0910, 16'h0110, 16'h1b10, 16'h0110,
		16'h1310, 16'h0300, 16'h1310, 16'h0421, 16'h1b10,
		16'h0511, 16'h0300, 16'h1f20, 16'h0701, 16'h0300,
		16'h1701, 16'h1310, 16'h0d20, 16'h1711, 16'h1310,
		16'h0701, 16'h0300, 16'h0501, 16'h0300, 16'h0421, 16'h1f21};
	icm_master DUT (.i_core_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_scl(scl), .o_scl(), .o_scl_oe_n(m_scl_oe_n), .i_sda(sda), .o_sda(),
		.o_sda_oe_n(m_sda_oe_n), .o_irq);
	icm_slave_model u_slave (.i_scl(scl), .i_sda(sda), .i_stretch(stretch), .i_tx(tx),
		.o_scl_oe_n(s_scl_oe_n), .o_sda_oe_n(s_sda_oe_n), .o_rx(rx_s));
	////////////////////////////////////////////////////////////////////
	function automatic int n_rises(input logic [3:0] c, input logic [3:0] kd);
		if (kd == 4'h2)
			return (c == 4'h4) ? 1 : 0;
		return (c[1] ? 19 : 9) + (c[2] ? 1 : 0);
	endfunction : n_rises
	task automatic chk(input icm_word_t seen, input icm_word_t exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input icm_addr_t a, input icm_word_t d);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input icm_addr_t a);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask : rd
	task automatic poll();
		v = 32'h1;
		for (int n = 0; n < 5000 && v[0] !== 1'b0; n++)
			rd(`ICM_OFF_CS);
	endtask : poll
	task automatic rchk(input icm_addr_t a, input icm_word_t exp);
		rd(a);
		chk(v, exp);
	endtask : rchk
	task automatic complete_run();
		if (err_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////////////
	always @(posedge m_scl_oe_n) begin
		rises++;
		gap = $time - tlast;
		tlast = $time;
	end
	initial begin
		i_core_clk = 1'b0;
		forever #25 i_core_clk = ~i_core_clk;
	end
	initial begin
		#4500000;
		err_count++;
		complete_run();
	end
	initial begin
		{i_rst_n, i_wr, i_rd, stretch, i_addr, i_wdata, tx} = '0;
		{err_count, checks, rises, tlast} = '0;
		v = $urandom(32'hd77d);
		repeat (6) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		rchk(`ICM_OFF_DR, 32'h0);
		rchk(`ICM_OFF_IMR, 32'h0);
		rchk(`ICM_OFF_ICR, 32'h0);
		wr(`ICM_OFF_TPR, 32'h0);
		rchk(`ICM_OFF_TPR, 32'h1);
		foreach (steps[k]) begin
			s = steps[k];
			tp = 8'($urandom_range(2, 1));
			dat = 8'($urandom);
			msk = 1'($urandom);
			stretch = 1'($urandom);
			tx = (s[12] && s[7:4] == 4'h0) ? 8'hff : 8'($urandom);
			wr(`ICM_OFF_TPR, 32'(tp));
			wr(`ICM_OFF_DR, 32'(dat));
			wr(`ICM_OFF_IMR, 32'(msk));
			wr(`ICM_OFF_SA, {24'h0, 7'h2a, s[12]});
			rises = 0;
			wr(`ICM_OFF_CS, 32'(s[11:8]));
			repeat (2) @(posedge i_core_clk);
			poll();
			chk(32'({v[5], v[0]}), 32'({s[0], 1'b0}));
			chk(32'(v[3:1]), (s[12] && s[7:4] == 4'h0) ? 32'h5 : 32'h0);
			chk(32'(rises), 32'(n_rises(s[11:8], s[7:4])));
			if (s[7:4] == 4'h0 && !s[12])
				chk(32'(rx_s), 32'(dat));
			if (s[7:4] == 4'h1)
				rchk(`ICM_OFF_DR, 32'(tx));
			if (!stretch && s[7:4] != 4'h2)
				chk(32'(gap), 32'(1000 * (tp + 1)));
			raw_exp = s[7:4] != 4'h2 || s[11:8] == 4'h4;
			chk(32'(o_irq), 32'(msk & raw_exp));
			rchk(`ICM_OFF_MIS, 32'(msk & raw_exp));
			wr(`ICM_OFF_ICR, 32'h0);
			rchk(`ICM_OFF_RIS, 32'(raw_exp));
			wr(`ICM_OFF_ICR, 32'h1);
			rchk(`ICM_OFF_RIS, 32'h0);
		end
		wr(`ICM_OFF_SA, 32'h0000_0062);
		wr(`ICM_OFF_CS, 32'h7);
		repeat (200) @(posedge i_core_clk);
		poll();
		chk(32'({v[2:1], v[0]}), 32'h6);
		wr(`ICM_OFF_SA, 32'h0000_0054);
		wr(`ICM_OFF_CS, 32'h3);
		repeat (2) @(posedge i_core_clk);
		poll();
		tx = 8'h00;
		wr(`ICM_OFF_DR, 32'h0000_0080);
		wr(`ICM_OFF_SA, 32'h0000_0055);
		wr(`ICM_OFF_CS, 32'h7);
		repeat (2) @(posedge i_core_clk);
		poll();
		chk(32'(v[6:0]), 32'h32);
		complete_run();
	end
endmodule : icm_master_tb_top
